// [src/bja_pkg.sv]
// package: shared constants, enums and carrier structs of the branch/jump address unit
package bja_pkg;

    localparam int unsigned XLEN        = 32;
    localparam int unsigned IMM_W       = 16;
    localparam int unsigned REGIDX_W    = 5;
    localparam int unsigned JIDX_W      = 26;
    localparam int unsigned REGION_W    = 4;
    localparam int unsigned WORD_SHIFT  = 2;
    localparam logic [31:0] PC_STEP     = 32'h0000_0004;
    localparam logic [31:0] LINK_OFFSET = 32'h0000_0008;
    localparam logic [4:0]  LINK_REG    = 5'h1F;
    localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

    // operation class presented by decode
    typedef enum logic [3:0] {
        BJA_OP_NONE   = 4'h0,
        BJA_OP_MEM    = 4'h1,
        BJA_OP_BRANCH = 4'h2,
        BJA_OP_JUMP   = 4'h3,
        BJA_OP_JREG   = 4'h4,
        BJA_OP_ADD    = 4'h5,
        BJA_OP_SUB    = 4'h6
    } bja_op_t;

    // branch condition
    typedef enum logic [2:0] {
        BJA_CND_EQ   = 3'h0,
        BJA_CND_NE   = 3'h1,
        BJA_CND_LEZ  = 3'h2,
        BJA_CND_GTZ  = 3'h3,
        BJA_CND_LTZ  = 3'h4,
        BJA_CND_GEZ  = 3'h5
    } bja_cond_t;

    // decoded request from the decode stage
    typedef struct packed {
        logic        valid;
        bja_op_t     op;
        bja_cond_t   cond;
        logic        likely;
        logic        link;
        logic        trap_ovf;
        logic [31:0] pc;
        logic [31:0] rs_val;
        logic [31:0] rt_val;
        logic [15:0] imm;
        logic [25:0] jidx;
        logic [4:0]  link_dest;
    } bja_req_t;

    // answer to fetch, memory and write-back
    typedef struct packed {
        logic        valid;
        logic        redirect;
        logic [31:0] target;
        logic        slot_nullify;
        logic        mem_valid;
        logic [31:0] mem_addr;
        logic        link_we;
        logic [4:0]  link_idx;
        logic [31:0] link_data;
        logic        alu_valid;
        logic [31:0] alu_result;
        logic        ovf_trap;
    } bja_rsp_t;

    // unit state machine
    typedef enum logic [1:0] {
        BJA_ST_IDLE = 2'b01,
        BJA_ST_SLOT = 2'b10
    } bja_state_t;

    // all state of the unit
    typedef struct packed {
        bja_state_t  state;
        logic        kill_slot;
        bja_rsp_t    rsp;
    } bja_regs_t;

endpackage

// [src/bja_unit.sv]
// module: branch, jump, link and effective-address computation for the integer pipeline
module bja_unit (
    // clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst_b,
    // decoded request
    input  wire bja_pkg::bja_req_t i_req,
    // answer to fetch, memory and write-back
    output bja_pkg::bja_rsp_t      o_rsp,
    // slot status for the following instruction
    output logic                   o_in_slot,
    output logic                   o_slot_kill
);

    bja_pkg::bja_regs_t st_reg;
    bja_pkg::bja_regs_t st_next;

    // =====================================================================
    // operand fields
    // =====================================================================
    logic [31:0] imm_word;
    logic [31:0] slot_pc;
    logic [31:0] link_pc;
    logic [31:0] br_target;
    logic [31:0] j_target;
    logic [31:0] ea_sum;
    logic [31:0] sum;
    logic [3:0]  pc_region;
    logic        rs_neg;
    logic        rs_zero;
    logic        rs_eq_rt;
    logic        cond_true;
    logic        is_sub;
    logic        a_sign;
    logic        b_sign;
    logic        r_sign;
    logic        ovf_raw;

    // =====================================================================
    // offset sign extension
    // =====================================================================
    wire logic [31:0] imm_sext;
    assign imm_sext[bja_pkg::IMM_W-1:0] = i_req.imm;
    for (genvar b = bja_pkg::IMM_W; b < bja_pkg::XLEN; b++) begin : g_sext
        assign imm_sext[b] = i_req.imm[bja_pkg::IMM_W-1];
    end

    // =====================================================================
    // address and condition datapath
    // =====================================================================
    always_comb begin
        // offset counts words, so the reach is four times the field range
        imm_word  = imm_sext << bja_pkg::WORD_SHIFT;
        slot_pc   = i_req.pc + bja_pkg::PC_STEP;
        // return skips the delay slot
        link_pc   = i_req.pc + bja_pkg::LINK_OFFSET;
        br_target = slot_pc + imm_word;
        pc_region = i_req.pc[bja_pkg::XLEN-1 -: bja_pkg::REGION_W];
        j_target  = {pc_region, i_req.jidx, 2'h0};
        // the only addressing mode: no index register, no absolute form
        ea_sum    = i_req.rs_val + imm_sext;
        rs_neg    = i_req.rs_val[bja_pkg::XLEN-1];
        rs_zero   = (i_req.rs_val == bja_pkg::ZERO_WORD);
        rs_eq_rt  = (i_req.rs_val == i_req.rt_val);
        // only register contents decide; no stored flags exist
        unique case (i_req.cond)
            bja_pkg::BJA_CND_EQ:  cond_true = rs_eq_rt;
            bja_pkg::BJA_CND_NE:  cond_true = !rs_eq_rt;
            bja_pkg::BJA_CND_LEZ: cond_true = rs_neg || rs_zero;
            bja_pkg::BJA_CND_GTZ: cond_true = !rs_neg && !rs_zero;
            bja_pkg::BJA_CND_LTZ: cond_true = rs_neg;
            bja_pkg::BJA_CND_GEZ: cond_true = !rs_neg;
            default:              cond_true = 1'b0;
        endcase
        is_sub  = (i_req.op == bja_pkg::BJA_OP_SUB);
        a_sign  = rs_neg;
        // subtract adds the inverted operand, so its sign flips too
        b_sign  = is_sub ? !i_req.rt_val[bja_pkg::XLEN-1]
                         : i_req.rt_val[bja_pkg::XLEN-1];
        sum     = is_sub ? i_req.rs_val - i_req.rt_val
                         : i_req.rs_val + i_req.rt_val;
        r_sign  = sum[bja_pkg::XLEN-1];
        // overflow: operands agree in sign, result differs
        ovf_raw = (a_sign == b_sign) && (r_sign != a_sign);
    end

    // =====================================================================
    // request qualifiers
    // =====================================================================
    logic        is_mem;
    logic        is_branch;
    logic        is_jump;
    logic        is_jreg;
    logic        is_alu;
    logic        is_xfer;
    logic        is_call;
    logic        is_taken;
    logic        slot_cancel;

    always_comb begin
        is_mem      = i_req.valid && (i_req.op == bja_pkg::BJA_OP_MEM);
        is_branch   = i_req.valid && (i_req.op == bja_pkg::BJA_OP_BRANCH);
        is_jump     = i_req.valid && (i_req.op == bja_pkg::BJA_OP_JUMP);
        is_jreg     = i_req.valid && (i_req.op == bja_pkg::BJA_OP_JREG);
        is_alu      = i_req.valid && (i_req.op == bja_pkg::BJA_OP_ADD ||
                                      i_req.op == bja_pkg::BJA_OP_SUB);
        is_xfer     = is_branch || is_jump || is_jreg;
        // calls link whether or not the condition holds
        is_call     = is_xfer && i_req.link;
        is_taken    = is_jump || is_jreg || (is_branch && cond_true);
        // a taken likely branch keeps its slot
        slot_cancel = is_branch && i_req.likely && !cond_true;
    end

    // =====================================================================
    // next state
    // =====================================================================
    always_comb begin
        st_next     = st_reg;
        st_next.rsp = '0;
        if (i_req.valid) begin
            st_next.rsp.valid = 1'b1;
            unique case (i_req.op)
                bja_pkg::BJA_OP_MEM: begin
                    st_next.rsp.mem_valid = is_mem;
                    st_next.rsp.mem_addr  = ea_sum;
                end
                bja_pkg::BJA_OP_BRANCH: begin
                    st_next.rsp.redirect = is_taken;
                    st_next.rsp.target   = br_target;
                    // likely form not taken kills the slot
                    st_next.rsp.slot_nullify = slot_cancel;
                end
                bja_pkg::BJA_OP_JUMP: begin
                    st_next.rsp.redirect = 1'b1;
                    st_next.rsp.target   = j_target;
                end
                bja_pkg::BJA_OP_JREG: begin
                    st_next.rsp.redirect = 1'b1;
                    st_next.rsp.target   = i_req.rs_val;
                end
                bja_pkg::BJA_OP_ADD,
                bja_pkg::BJA_OP_SUB: begin
                    st_next.rsp.alu_valid  = is_alu;
                    st_next.rsp.alu_result = sum;
                    // non-trapping forms never flag
                    st_next.rsp.ovf_trap = i_req.trap_ovf && ovf_raw;
                end
                default: st_next.rsp.valid = 1'b1;
            endcase
            // link only for calls; a branch call links even when not taken
            if (is_call) begin
                st_next.rsp.link_we   = 1'b1;
                st_next.rsp.link_idx  = bja_pkg::LINK_REG;
                st_next.rsp.link_data = link_pc;
            end
        end
        // slot tracking: next valid instruction after a transfer is the slot
        unique case (st_reg.state)
            bja_pkg::BJA_ST_IDLE: begin
                if (is_xfer) begin
                    st_next.state     = bja_pkg::BJA_ST_SLOT;
                    st_next.kill_slot = st_next.rsp.slot_nullify;
                end
            end
            bja_pkg::BJA_ST_SLOT: begin
                // the slot itself is not a transfer; it leaves the slot window
                if (i_req.valid) begin
                    st_next.state     = bja_pkg::BJA_ST_IDLE;
                    st_next.kill_slot = 1'b0;
                end
            end
            default: begin
                st_next.state     = bja_pkg::BJA_ST_IDLE;
                st_next.kill_slot = 1'b0;
            end
        endcase
    end

    // =====================================================================
    // registers
    // =====================================================================
    always_ff @(posedge i_clk_sys) begin
        // synchronous reset; answer fields clear so no stale pulse follows
        if (!i_rst_b) begin
            st_reg.rsp       <= '0;
            st_reg.kill_slot <= 1'b0;
            st_reg.state     <= bja_pkg::BJA_ST_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // =====================================================================
    // outputs, taken from the state register
    // =====================================================================
    assign o_rsp       = st_reg.rsp;
    assign o_in_slot   = (st_reg.state == bja_pkg::BJA_ST_SLOT);
    assign o_slot_kill = st_reg.kill_slot;

endmodule

// [dv/bja_unit_properties.sv]
// checker: port-level properties of the branch/jump address unit
module bja_unit_properties (
    input wire logic              i_clk_sys,
    input wire logic              i_rst_b,
    input wire bja_pkg::bja_req_t i_req,
    input wire bja_pkg::bja_rsp_t o_rsp,
    input wire logic              o_in_slot,
    input wire logic              o_slot_kill
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);
    // ==========================================
    // expected values; a transfer in the slot is not a transfer
    logic [31:0] sx, em, eb, ej, el;
    logic        tx, eq;
    assign sx = {{16{i_req.imm[15]}}, i_req.imm};
    assign em = i_req.rs_val + sx;
    assign eb = i_req.pc + 32'h4 + (sx << 2);
    assign ej = {i_req.pc[31:28], i_req.jidx, 2'h0};
    assign el = i_req.pc + 32'h8;
    assign tx = i_req.valid && !o_in_slot;
    assign eq = tx && i_req.op == bja_pkg::BJA_OP_BRANCH && i_req.cond == bja_pkg::BJA_CND_EQ;
    property p_mem; i_req.valid && i_req.op == bja_pkg::BJA_OP_MEM |=> o_rsp.mem_addr == $past(em); endproperty
    a_mem: assert property (p_mem) else $error("mem address");
    property p_jmp; tx && i_req.op == bja_pkg::BJA_OP_JUMP |=> o_rsp.target == $past(ej); endproperty
    a_jmp: assert property (p_jmp) else $error("jump target");
    property p_lnk;
        tx && i_req.link && (i_req.op == bja_pkg::BJA_OP_JUMP || i_req.op == bja_pkg::BJA_OP_JREG)
        |=> o_rsp.link_we && o_rsp.link_idx == 5'h1F && o_rsp.link_data == $past(el);
    endproperty
    a_lnk: assert property (p_lnk) else $error("link value");
    property p_jr; tx && i_req.op == bja_pkg::BJA_OP_JREG |=> o_rsp.target == $past(i_req.rs_val); endproperty
    a_jr: assert property (p_jr) else $error("indirect target");
    property p_slot; eq && !i_req.likely |=> o_in_slot && !o_slot_kill; endproperty
    a_slot: assert property (p_slot) else $error("slot kept");
    property p_lkl; eq && i_req.likely && i_req.rs_val != i_req.rt_val |=> o_slot_kill; endproperty
    a_lkl: assert property (p_lkl) else $error("slot cancel");
    property p_brt; eq && i_req.rs_val == i_req.rt_val |=> o_rsp.redirect && o_rsp.target == $past(eb); endproperty
    a_brt: assert property (p_brt) else $error("branch target");
    property p_ovf; i_req.valid && !i_req.trap_ovf |=> !o_rsp.ovf_trap; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag");
endmodule
bind bja_unit bja_unit_properties bja_unit_properties_i (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_req(i_req), .o_rsp(o_rsp), .o_in_slot(o_in_slot), .o_slot_kill(o_slot_kill));

// [dv/bja_rf_model.sv]
// partner: write side of the register file, catching link writes
module bja_rf_model (
    input  wire logic              i_clk_sys,
    input  wire bja_pkg::bja_rsp_t i_rsp,
    output logic [31:0]            o_ra
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] regs [32];
    always @(posedge i_clk_sys) begin
        if (i_rsp.valid && i_rsp.link_we) begin
            regs[i_rsp.link_idx] <= i_rsp.link_data;
        end
    end
    assign o_ra = regs[31];
endmodule

// [dv/bja_unit_test.sv]
// testbench: directed scenarios for the branch/jump address unit
module bja_unit_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic              i_clk_sys = 1'b0;
    logic              i_rst_b   = 1'b0;
    bja_pkg::bja_req_t i_req     = '0;
    bja_pkg::bja_rsp_t o_rsp;
    logic              o_in_slot, o_slot_kill;
    logic [31:0]       ra;
    int                n_errors  = 0;
    int                checked   = 0;
    always #12.5 i_clk_sys = ~i_clk_sys;
    bja_unit bja_unit_i (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_req(i_req), .o_rsp(o_rsp),
        .o_in_slot(o_in_slot), .o_slot_kill(o_slot_kill));
    bja_rf_model bja_rf_model_i (.i_clk_sys(i_clk_sys), .i_rsp(o_rsp), .o_ra(ra));
    // ==========================================
    // shared tasks; answer is looked at in its one standing cycle
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic bja_pkg::bja_req_t rq(input bja_pkg::bja_op_t op, input logic [31:0] pc,
        input logic [31:0] rs, input logic [31:0] rt, input logic [15:0] imm);
        rq = '0;
        rq.valid = 1'b1;
        rq.op = op;
        rq.pc = pc;
        rq.rs_val = rs;
        rq.rt_val = rt;
        rq.imm = imm;
    endfunction
    task automatic go(input bja_pkg::bja_req_t r);
        @(negedge i_clk_sys);
        i_req = r;
        @(negedge i_clk_sys);
        i_req = '0;
    endtask
    task automatic fill;
        go(rq(bja_pkg::BJA_OP_NONE, 32'h0, 32'h0, 32'h0, 16'h0));
        chk("in_slot", 32'h0, 32'(o_in_slot));
    endtask
    // ==========================================
    // scenarios
    task automatic t_mem;
        go(rq(bja_pkg::BJA_OP_MEM, 32'h0, 32'h1000, 32'h0, 16'h8000));
        chk("mem_addr", 32'hFFFF_9000, o_rsp.mem_addr);
        chk("mem_valid", 32'h1, 32'(o_rsp.mem_valid));
        go(rq(bja_pkg::BJA_OP_MEM, 32'h0, 32'h1000, 32'h0, 16'h7FFF));
        chk("mem_addr", 32'h0000_8FFF, o_rsp.mem_addr);
        $display("test mem done");
    endtask
    task automatic t_jump;
        bja_pkg::bja_req_t r;
        r = rq(bja_pkg::BJA_OP_JUMP, 32'hA000_0010, 32'h0, 32'h0, 16'h0);
        r.jidx = 26'h3FF_FFFF;
        r.link = 1'b1;
        go(r);
        chk("target", 32'hAFFF_FFFC, o_rsp.target);
        chk("redirect", 32'h1, 32'(o_rsp.redirect));
        chk("in_slot", 32'h1, 32'(o_in_slot));
        fill;
        chk("ra", 32'hA000_0018, ra);
        r = rq(bja_pkg::BJA_OP_JREG, 32'h0000_0040, 32'h8765_4321, 32'h0, 16'h0);
        r.link = 1'b1;
        r.link_dest = 5'h05;
        go(r);
        chk("target", 32'h8765_4321, o_rsp.target);
        fill;
        chk("ra", 32'h0000_0048, ra);
        $display("test jump done");
    endtask
    task automatic t_branch;
        go(rq(bja_pkg::BJA_OP_BRANCH, 32'h0002_0000, 32'h0, 32'h0, 16'h8000));
        chk("target", 32'h0000_0004, o_rsp.target);
        chk("kill", 32'h0, 32'(o_slot_kill));
        fill;
        go(rq(bja_pkg::BJA_OP_BRANCH, 32'h0, 32'h1, 32'h2, 16'h4));
        chk("redirect", 32'h0, 32'(o_rsp.redirect));
        chk("in_slot", 32'h1, 32'(o_in_slot));
        fill;
        $display("test branch done");
    endtask
    task automatic t_likely;
        bja_pkg::bja_req_t r;
        r = rq(bja_pkg::BJA_OP_BRANCH, 32'h0, 32'h1, 32'h2, 16'h4);
        r.likely = 1'b1;
        go(r);
        chk("nullify", 32'h1, 32'(o_rsp.slot_nullify));
        chk("kill", 32'h1, 32'(o_slot_kill));
        fill;
        $display("test likely done");
    endtask
    task automatic t_ovf;
        bja_pkg::bja_req_t r;
        for (int k = 0; k < 4; k++) begin
            r = rq(k[1] ? bja_pkg::BJA_OP_SUB : bja_pkg::BJA_OP_ADD, 32'h0,
                k[1] ? 32'h8000_0000 : 32'h7FFF_FFFF, 32'h1, 16'h0);
            r.trap_ovf = k[0];
            go(r);
            chk("ovf_trap", {31'h0, k[0]}, 32'(o_rsp.ovf_trap));
            chk("alu_result", k[1] ? 32'h7FFF_FFFF : 32'h8000_0000, o_rsp.alu_result);
        end
        $display("test overflow done");
    endtask
    // every condition against zero, positive and negative rs; rt is zero
    task automatic t_cond;
        bja_pkg::bja_req_t r;
        logic [17:0]       e;
        e = 18'h16AA5;
        for (int i = 0; i < 18; i++) begin
            r = rq(bja_pkg::BJA_OP_BRANCH, 32'h0,
                (i < 6) ? 32'h0 : ((i < 12) ? 32'h1 : 32'h8000_0000), 32'h0, 16'h0);
            r.cond = bja_pkg::bja_cond_t'(3'(i % 6));
            go(r);
            chk("redirect", 32'(e[i]), 32'(o_rsp.redirect));
            fill;
        end
        $display("test conditions done");
    endtask
    // ==========================================
    // run and verdict
    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge i_clk_sys);
        i_rst_b = 1'b1;
        t_mem;
        t_jump;
        t_branch;
        t_likely;
        t_ovf;
        t_cond;
        final_report;
    end
    // about 110 cycles expected; generous margin
    initial begin
        repeat (400) @(posedge i_clk_sys);
        n_errors++;
        final_report;
    end
endmodule
